/* dv/rpf_host.sv */
`timescale 1ns/1ps
// ***************************************************************
// Serial host sending phase strings
// ***************************************************************
module rpf_host (
    input  wire logic       i_core_clk,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
    end

    // Strings hold only 00..7e, no ACK/NAK, at most 32 chars
    task automatic send(input logic [255:0] s, input logic [5:0] n);
        for (int k = 0; k < 32 && k < n; k++) begin
            @(posedge i_core_clk);
            o_rx_valid <= 1'b1;
            o_rx_data  <= s[8*k +: 8];
        end
        @(posedge i_core_clk);
        o_rx_valid <= 1'b0;
        // Released line no longer shows the last char
        o_rx_data  <= ~o_rx_data;
        #1;
    endtask
endmodule

/* dv/rpf_top_test.sv */
`timescale 1ns/1ps
module rpf_top_test;
    import rpf_pkg::*;
    // Start and stop strings kept distinct
    localparam logic [255:0] START_S = 256'h4f47;
    localparam logic [255:0] STOP_S  = 256'h5053;
    localparam logic [31:0]  SEQ_D [7] = '{32'ha, 32'hb, 32'hb, 32'hc, 32'hd, 32'ha, 32'ha};
    localparam logic [6:0]   SEQ_OK    = 7'b1101110;
    logic              i_core_clk, i_rst_n, i_tmo_en, i_rx_valid, i_start_in, i_stop_in;
    logic              i_code_valid, i_code_noread, i_enc_step, i_mm_step;
    rpf_mode_t         i_mode;
    rpf_shut_t         i_shutter;
    rpf_origin_t       i_origin;
    rpf_flush_t        i_flush;
    logic [13:0]       i_tmo_ms, i_flush_lim;
    logic [255:0]      i_start_str, i_stop_str;
    logic [5:0]        i_start_len, i_stop_len;
    logic [7:0]        i_rx_data, i_code_len, o_tx_len;
    logic [31:0]       i_code_data, o_tx_data;
    logic [6:0]        i_depth;
    logic              o_phase_active, o_laser_en, o_tx_valid, o_tx_noread;
    int                num_errors, checks_done;

    rpf_top #(.CLK_PER_MS(4), .DEPTH(8)) rpf_top_i (.i_core_clk, .i_rst_n, .i_mode, .i_shutter, .i_tmo_en,
        .i_tmo_ms, .i_origin, .i_start_str, .i_start_len, .i_stop_str, .i_stop_len, .i_rx_valid, .i_rx_data,
        .i_start_in, .i_stop_in, .i_code_valid, .i_code_noread, .i_code_data, .i_code_len, .i_depth, .i_flush,
        .i_flush_lim, .i_enc_step, .i_mm_step, .o_phase_active, .o_laser_en, .o_tx_valid, .o_tx_noread,
        .o_tx_data, .o_tx_len);
    rpf_host rpf_host_i (.i_core_clk(i_core_clk), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));

    // ***************************************************************
    // Tasks
    // ***************************************************************
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic wait_phase(input logic v, input int lim);
        int k;
        k = 0;
        while (o_phase_active !== v && k < lim) begin
            cyc(1);
            k++;
        end
        chk(o_phase_active, v);
    endtask
    task automatic code(input logic [31:0] d, input logic [7:0] l, input logic nr, input logic exp);
        @(posedge i_core_clk);
        i_code_valid  <= 1'b1;
        i_code_data   <= d;
        i_code_len    <= l;
        i_code_noread <= nr;
        @(posedge i_core_clk);
        i_code_valid  <= 1'b0;
        #1;
        chk(o_tx_valid, exp);
        if (exp) chk({o_tx_data[23:0], o_tx_len}, {d[23:0], l});
        if (exp) chk(o_tx_noread, nr);
    endtask
    task automatic pulse(input int w, input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            if (w == 0) i_start_in <= 1'b1;
            else if (w == 1) i_stop_in <= 1'b1;
            else if (w == 2) i_enc_step <= 1'b1;
            else i_mm_step <= 1'b1;
            @(posedge i_core_clk);
            {i_start_in, i_stop_in, i_enc_step, i_mm_step} <= 4'h0;
        end
        cyc(2);
    endtask
    task automatic do_reset;
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        cyc(2);
    endtask

    // ***************************************************************
    // Sequence
    // ***************************************************************
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        num_errors++;
        stop_test();
    end
    initial begin
        {i_rst_n, i_tmo_en, i_start_in, i_stop_in, i_code_valid, i_code_noread, i_enc_step, i_mm_step} = 8'h00;
        i_mode = RPF_MODE_SERIAL;
        i_shutter = RPF_SHUT_DIS;
        i_origin = RPF_FROM_START;
        i_flush = RPF_FL_NONE;
        i_tmo_ms = 14'd40;
        i_flush_lim = 14'd2;
        i_start_str = START_S;
        i_stop_str = STOP_S;
        i_start_len = 6'h2;
        i_stop_len = 6'h2;
        i_code_data = 32'h0;
        i_code_len = 8'h0;
        i_depth = 7'h3;
        do_reset();
        chk(o_laser_en, 1'b1);
        chk(o_phase_active, 1'b0);
        rpf_host_i.send(START_S, 6'h2);
        wait_phase(1'b1, 4);
        rpf_host_i.send(STOP_S, 6'h2);
        wait_phase(1'b0, 4);
        $display("test serial strings done");
        @(posedge i_core_clk);
        i_tmo_en <= 1'b1;
        rpf_host_i.send(START_S, 6'h2);
        cyc(140);
        chk(o_phase_active, 1'b1);
        wait_phase(1'b0, 40);
        @(posedge i_core_clk);
        i_origin <= RPF_FROM_STOP;
        pulse(0, 1);
        wait_phase(1'b1, 4);
        pulse(1, 1);
        cyc(140);
        chk(o_phase_active, 1'b1);
        wait_phase(1'b0, 40);
        $display("test timeout done");
        @(posedge i_core_clk);
        i_tmo_en <= 1'b0;
        i_shutter <= RPF_SHUT_TRIG;
        rpf_host_i.send(START_S, 6'h2);
        wait_phase(1'b1, 4);
        chk(o_laser_en, 1'b1);
        code(32'h5, 8'h3, 1'b0, 1'b1);
        cyc(1);
        chk({o_laser_en, o_phase_active}, 2'b01);
        rpf_host_i.send(STOP_S, 6'h2);
        wait_phase(1'b0, 4);
        rpf_host_i.send(START_S, 6'h2);
        wait_phase(1'b1, 4);
        code(32'h6, 8'h2, 1'b1, 1'b1);
        chk(o_laser_en, 1'b1);
        rpf_host_i.send(STOP_S, 6'h2);
        wait_phase(1'b0, 4);
        cyc(1);
        chk(o_laser_en, 1'b0);
        @(posedge i_core_clk);
        i_shutter <= RPF_SHUT_ENA;
        rpf_host_i.send(START_S, 6'h2);
        cyc(4);
        chk({o_laser_en, o_phase_active}, 2'b00);
        $display("test shutter done");
        @(posedge i_core_clk);
        i_shutter <= RPF_SHUT_DIS;
        i_mode <= RPF_MODE_CONT;
        wait_phase(1'b1, 4);
        code(32'h9, 8'h4, 1'b1, 1'b0);
        for (int i = 0; i < 7; i++) code(SEQ_D[i], 8'h4, 1'b0, SEQ_OK[6-i]);
        code(32'ha, 8'h6, 1'b0, 1'b1);
        code(32'ha, 8'h6, 1'b0, 1'b0);
        @(posedge i_core_clk);
        i_depth <= 7'h0;
        code(32'ha, 8'h4, 1'b0, 1'b1);
        code(32'ha, 8'h4, 1'b0, 1'b1);
        $display("test filter list done");
        @(posedge i_core_clk);
        i_depth <= 7'h3;
        i_flush <= RPF_FL_ENC;
        code(32'he, 8'h4, 1'b0, 1'b1);
        pulse(2, 2);
        code(32'he, 8'h4, 1'b0, 1'b0);
        pulse(2, 1);
        code(32'he, 8'h4, 1'b0, 1'b1);
        @(posedge i_core_clk);
        i_flush <= RPF_FL_TXL;
        code(32'hf, 8'h4, 1'b0, 1'b1);
        pulse(3, 3);
        code(32'hf, 8'h4, 1'b0, 1'b1);
        @(posedge i_core_clk);
        i_flush <= RPF_FL_TIME;
        code(32'h7, 8'h4, 1'b0, 1'b1);
        code(32'h7, 8'h4, 1'b0, 1'b0);
        cyc(16);
        code(32'h7, 8'h4, 1'b0, 1'b1);
        @(posedge i_core_clk);
        i_flush <= RPF_FL_NONE;
        code(32'h8, 8'h4, 1'b0, 1'b1);
        do_reset();
        wait_phase(1'b1, 4);
        code(32'h8, 8'h4, 1'b0, 1'b1);
        $display("test flush and reset done");
        stop_test();
    end
endmodule

/* rtl/rpf_list.sv */
`timescale 1ns/1ps
`include "rpf_map.svh"
module rpf_list
    import rpf_pkg::*;
#(
    parameter int DEPTH = `RPF_DEPTH_MAX,
    parameter int KEY_W = 40
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_lookup,
    input  wire logic [KEY_W-1:0]      i_key,
    input  wire logic [`RPF_DEPTH_W-1:0] i_depth,
    input  rpf_flush_t                 i_flush,
    input  wire logic                  i_age_ev,
    input  wire logic [`RPF_AGE_W-1:0] i_lim,
    output logic                       o_hit
);
    logic [KEY_W-1:0]      key_reg [DEPTH];
    logic [`RPF_AGE_W-1:0] age_reg [DEPTH];
    logic [DEPTH-1:0]      vld_reg;
    logic                  hit;
    logic                  on;
    int                    lim_idx;

    // ***************************************************************
    // Lookup on content and length
    // ***************************************************************
    always_comb begin
        hit = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (vld_reg[i] && key_reg[i] == i_key) begin
                hit = 1'b1;
            end
        end
    end

    // Transmit-line tracking ignores the depth and uses the whole list
    assign on      = (i_flush == RPF_FL_TXL) || (i_depth != '0);
    assign lim_idx = (i_flush == RPF_FL_TXL) ? DEPTH : int'(i_depth);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hit <= 1'b0;
        end else begin
            o_hit <= i_lookup && on && hit;
        end
    end

    // ***************************************************************
    // Insert, age and flush
    // ***************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vld_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                key_reg[i] <= '0;
                age_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (i_age_ev && age_reg[i] != '1) begin
                    age_reg[i] <= age_reg[i] + 1'b1;
                end
                if (!on || i >= lim_idx) begin
                    vld_reg[i] <= 1'b0;
                end else if (i_flush == RPF_FL_TIME && age_reg[i] >= i_lim) begin
                    vld_reg[i] <= 1'b0;
                end else if (i_flush == RPF_FL_ENC && age_reg[i] > i_lim) begin
                    vld_reg[i] <= 1'b0;
                end else if (i_flush == RPF_FL_TXL && age_reg[i] > i_lim) begin
                    vld_reg[i] <= 1'b0;
                end
            end
            if (i_lookup && on && !hit) begin
                // New code at the head, the rest move down, the tail falls off
                for (int i = DEPTH - 1; i > 0; i--) begin
                    key_reg[i] <= key_reg[i-1];
                    age_reg[i] <= age_reg[i-1];
                    vld_reg[i] <= vld_reg[i-1] && (i < lim_idx);
                end
                key_reg[0] <= i_key;
                age_reg[0] <= '0;
                vld_reg[0] <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    AST_SAME_KEY_DROPPED: assert property (
        i_lookup && on && !hit && i_flush == RPF_FL_NONE && i_depth > 1
        ##1 $stable(i_key) && $stable(i_depth) && $stable(i_flush)
        ##1 i_lookup && $stable(i_key) && $stable(i_depth) && $stable(i_flush)
        |=> o_hit) else $error("Repeated code not found in list");
    AST_EMPTY_AT_ZERO: assert property (
        i_flush != RPF_FL_TXL && i_depth == '0 |=> vld_reg == '0 && !o_hit)
        else $error("List holds entries with zero depth");
    COV_DUP: cover property (o_hit);
endmodule

/* rtl/rpf_map.svh */
`ifndef RPF_MAP_SVH
`define RPF_MAP_SVH

// ***************************************************************
// Timing
// ***************************************************************
`define RPF_CLK_HZ       40000000
`define RPF_TICK_MS      1
`define RPF_TMO_MIN_MS   14'd40
`define RPF_TMO_MAX_MS   14'd15000

// ***************************************************************
// Sizes
// ***************************************************************
`define RPF_STR_MAX      32
`define RPF_STR_LEN_W    6
`define RPF_DEPTH_MAX    127
`define RPF_DEPTH_W      7
`define RPF_AGE_W        14
`define RPF_CHAR_MAX     8'h7e

`endif

/* rtl/rpf_pkg.sv */
package rpf_pkg;
    typedef enum logic {RPF_MODE_SERIAL, RPF_MODE_CONT} rpf_mode_t;
    typedef enum logic {RPF_FROM_START, RPF_FROM_STOP} rpf_origin_t;
    typedef enum logic [1:0] {RPF_SHUT_DIS, RPF_SHUT_TRIG, RPF_SHUT_ENA} rpf_shut_t;
    typedef enum logic [1:0] {RPF_FL_NONE, RPF_FL_TIME, RPF_FL_ENC, RPF_FL_TXL} rpf_flush_t;
    typedef enum logic [1:0] {RPF_ST_IDLE, RPF_ST_OPEN, RPF_ST_EXTEND} rpf_state_t;
endpackage

/* rtl/rpf_top.sv */
`timescale 1ns/1ps
`include "rpf_map.svh"
module rpf_top
    import rpf_pkg::*;
#(
    parameter int CLK_PER_MS = `RPF_CLK_HZ / 1000 * `RPF_TICK_MS,
    parameter int DEPTH      = `RPF_DEPTH_MAX,
    parameter int CODE_W     = 32,
    parameter int LEN_W      = 8
) (
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rst_n,
    input  rpf_mode_t                         i_mode,
    input  rpf_shut_t                         i_shutter,
    input  wire logic                         i_tmo_en,
    input  wire logic [`RPF_AGE_W-1:0]        i_tmo_ms,
    input  rpf_origin_t                       i_origin,
    input  wire logic [`RPF_STR_MAX*8-1:0]    i_start_str,
    input  wire logic [`RPF_STR_LEN_W-1:0]    i_start_len,
    input  wire logic [`RPF_STR_MAX*8-1:0]    i_stop_str,
    input  wire logic [`RPF_STR_LEN_W-1:0]    i_stop_len,
    input  wire logic                         i_rx_valid,
    input  wire logic [7:0]                   i_rx_data,
    input  wire logic                         i_start_in,
    input  wire logic                         i_stop_in,
    input  wire logic                         i_code_valid,
    input  wire logic                         i_code_noread,
    input  wire logic [CODE_W-1:0]            i_code_data,
    input  wire logic [LEN_W-1:0]             i_code_len,
    input  wire logic [`RPF_DEPTH_W-1:0]      i_depth,
    input  rpf_flush_t                        i_flush,
    input  wire logic [`RPF_AGE_W-1:0]        i_flush_lim,
    input  wire logic                         i_enc_step,
    input  wire logic                         i_mm_step,
    output logic                              o_phase_active,
    output logic                              o_laser_en,
    output logic                              o_tx_valid,
    output logic                              o_tx_noread,
    output logic [CODE_W-1:0]                 o_tx_data,
    output logic [LEN_W-1:0]                  o_tx_len
);
    localparam int DIV_W = $clog2(CLK_PER_MS + 1);

    rpf_state_t                  state_reg;
    rpf_state_t                  state_next;
    logic [`RPF_STR_MAX*8-1:0]   hist_reg;
    logic [`RPF_STR_MAX*8-1:0]   hist_next;
    logic [DIV_W-1:0]            div_reg;
    logic                        ms_tick;
    logic [`RPF_AGE_W-1:0]       cnt_reg;
    logic [`RPF_AGE_W-1:0]       tmo_lim;
    logic                        expired;
    logic                        suspend;
    logic                        start_hit;
    logic                        stop_hit;
    logic                        start_ev;
    logic                        stop_ev;
    logic                        act_next;
    logic                        code_read;
    logic                        lookup;
    logic                        age_ev;
    logic                        hit;
    logic                        pend_reg;
    logic                        filt_reg;

    // Tail of the received stream equals the first len chars of the string
    function automatic logic str_match(input logic [`RPF_STR_MAX*8-1:0] hist,
                                       input logic [`RPF_STR_MAX*8-1:0] str,
                                       input logic [`RPF_STR_LEN_W-1:0] len);
        logic ok;
        ok = (len != '0);
        for (int i = 0; i < `RPF_STR_MAX; i++) begin
            if (i < int'(len) && hist[i*8 +: 8] != str[(int'(len) - 1 - i)*8 +: 8]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // ***************************************************************
    // Millisecond tick and serial string detection
    // ***************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg <= '0;
        end else if (ms_tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign ms_tick = (div_reg == DIV_W'(CLK_PER_MS - 1));

    assign hist_next = {hist_reg[`RPF_STR_MAX*8-9:0], i_rx_data};
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hist_reg <= '0;
        end else if (i_rx_valid) begin
            hist_reg <= hist_next;
        end
    end

    assign suspend   = (i_shutter == RPF_SHUT_ENA);
    assign start_hit = i_rx_valid && str_match(hist_next, i_start_str, i_start_len);
    assign stop_hit  = i_rx_valid && str_match(hist_next, i_stop_str, i_stop_len);
    assign start_ev  = start_hit || i_start_in;
    assign stop_ev   = stop_hit || i_stop_in;

    // ***************************************************************
    // Reading phase sequencer
    // ***************************************************************
    assign tmo_lim = (i_tmo_ms < `RPF_TMO_MIN_MS) ? `RPF_TMO_MIN_MS :
                     (i_tmo_ms > `RPF_TMO_MAX_MS) ? `RPF_TMO_MAX_MS : i_tmo_ms;
    assign expired = i_tmo_en && (cnt_reg >= tmo_lim);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RPF_ST_IDLE: begin
                if (start_ev) begin
                    state_next = RPF_ST_OPEN;
                end
            end
            RPF_ST_OPEN: begin
                if (stop_ev) begin
                    state_next = (i_tmo_en && i_origin == RPF_FROM_STOP) ? RPF_ST_EXTEND : RPF_ST_IDLE;
                end else if (i_origin == RPF_FROM_START && expired) begin
                    state_next = RPF_ST_IDLE;
                end
            end
            RPF_ST_EXTEND: begin
                if (start_ev) begin
                    state_next = RPF_ST_OPEN;
                end else if (expired) begin
                    state_next = RPF_ST_IDLE;
                end
            end
            default: begin
                state_next = RPF_ST_IDLE;
            end
        endcase
        if (suspend || i_mode == RPF_MODE_CONT) begin
            state_next = RPF_ST_IDLE;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= RPF_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Counter restarts on every entry into a timed state
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
        end else if (state_next != state_reg) begin
            cnt_reg <= '0;
        end else if (ms_tick && cnt_reg < tmo_lim) begin
            // Stops at the limit so it never wraps while no timeout is in use
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign act_next = !suspend && (i_mode == RPF_MODE_CONT || state_next != RPF_ST_IDLE);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phase_active <= 1'b0;
        end else begin
            o_phase_active <= act_next;
        end
    end

    // ***************************************************************
    // Laser shutter
    // ***************************************************************
    assign code_read = i_code_valid && !i_code_noread && o_phase_active;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_laser_en <= 1'b0;
        end else if (i_shutter == RPF_SHUT_DIS) begin
            o_laser_en <= 1'b1;
        end else if (suspend) begin
            o_laser_en <= 1'b0;
        end else if (code_read || (o_phase_active && !act_next)) begin
            o_laser_en <= 1'b0;
        end else if ((act_next && !o_phase_active) || start_ev) begin
            o_laser_en <= 1'b1;
        end
    end

    // ***************************************************************
    // Code output with duplicate filter
    // ***************************************************************
    assign lookup = i_code_valid && o_phase_active && !i_code_noread && i_mode == RPF_MODE_CONT;
    always_comb begin
        case (i_flush)
            RPF_FL_TIME: age_ev = ms_tick;
            RPF_FL_ENC:  age_ev = i_enc_step;
            RPF_FL_TXL:  age_ev = i_mm_step;
            default:     age_ev = 1'b0;
        endcase
    end

    rpf_list #(
        .DEPTH (DEPTH),
        .KEY_W (CODE_W + LEN_W)
    ) u_list (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_lookup   (lookup),
        .i_key      ({i_code_len, i_code_data}),
        .i_depth    (i_depth),
        .i_flush    (i_flush),
        .i_age_ev   (age_ev),
        .i_lim      (i_flush_lim),
        .o_hit      (hit)
    );

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_reg    <= 1'b0;
            filt_reg    <= 1'b0;
            o_tx_noread <= 1'b0;
            o_tx_data   <= '0;
            o_tx_len    <= '0;
        end else begin
            pend_reg    <= i_code_valid && o_phase_active &&
                           !(i_code_noread && i_mode == RPF_MODE_CONT);
            filt_reg    <= lookup;
            o_tx_noread <= i_code_noread;
            o_tx_data   <= i_code_data;
            o_tx_len    <= i_code_len;
        end
    end
    assign o_tx_valid = pend_reg && !(filt_reg && hit);

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    AST_STOP_CLOSES: assert property (
        state_reg == RPF_ST_OPEN && stop_hit && !(i_tmo_en && i_origin == RPF_FROM_STOP) && !suspend
        && i_mode == RPF_MODE_SERIAL |=> state_reg == RPF_ST_IDLE ##1 !o_phase_active)
        else $error("Stop string did not close the phase");
    AST_NO_TMO_HOLDS: assert property (
        state_reg == RPF_ST_OPEN && !i_tmo_en && !stop_ev && !suspend && i_mode == RPF_MODE_SERIAL
        |=> state_reg == RPF_ST_OPEN) else $error("Phase closed without timeout enabled");
    AST_CNT_BOUND: assert property (
        cnt_reg <= `RPF_TMO_MAX_MS) else $error("Timeout counter beyond maximum");
    AST_START_TIMES: assert property (
        state_reg == RPF_ST_OPEN && i_origin == RPF_FROM_START && expired && !stop_ev && !suspend
        && i_mode == RPF_MODE_SERIAL |=> state_reg == RPF_ST_IDLE && cnt_reg == '0)
        else $error("Start-origin timeout did not end phase");
    AST_OPEN_ON_START: assert property (
        state_reg == RPF_ST_IDLE && start_hit && !suspend && i_mode == RPF_MODE_SERIAL
        |=> state_reg == RPF_ST_OPEN ##1 o_phase_active) else $error("Start string did not open phase");
    AST_STOP_EXTENDS: assert property (
        state_reg == RPF_ST_OPEN && stop_ev && i_tmo_en && i_origin == RPF_FROM_STOP && !suspend
        && i_mode == RPF_MODE_SERIAL |=> state_reg == RPF_ST_EXTEND && cnt_reg == '0)
        else $error("Stop-origin timing not started");
    AST_LASER_ON: assert property (
        i_rst_n && i_shutter == RPF_SHUT_DIS |=> o_laser_en) else $error("Laser off with shutter disabled");
    AST_LASER_TRIG_OFF: assert property (
        i_shutter == RPF_SHUT_TRIG && code_read |=> !o_laser_en) else $error("Laser stayed on after read");
    AST_SUSPEND: assert property (
        suspend ##1 suspend |-> !o_laser_en && !o_phase_active ##1 !o_tx_valid)
        else $error("Reading not suspended");
    AST_CONT_ACTIVE: assert property (
        i_rst_n && i_mode == RPF_MODE_CONT && !suspend |=> o_phase_active) else $error("Continuous phase inactive");
    AST_NOREAD_SILENT: assert property (
        i_mode == RPF_MODE_CONT && i_code_valid && i_code_noread |=> !o_tx_valid)
        else $error("No-read sent in continuous mode");

    COV_OPEN: cover property (state_reg == RPF_ST_IDLE ##1 state_reg == RPF_ST_OPEN);
    COV_EXTEND: cover property (state_reg == RPF_ST_EXTEND ##1 state_reg == RPF_ST_IDLE);
    COV_TX: cover property (o_tx_valid && i_mode == RPF_MODE_CONT);
    COV_TMO: cover property (expired && state_reg == RPF_ST_OPEN);
endmodule
